// ---- rtl/ldm_dimming_ctrl.sv ----
// dimming mode selection, duty measurement and fault flagging for eight strings
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ldm_dimming_ctrl
  import ldm_pkg::*;
#(
  parameter int unsigned TICK_DIV = ldm_pkg::LDM_TICK_DIV
)
(
  // clock and reset
  input  wire logic                            ref_clk_in,
  input  wire logic                            sys_rst_in,
  // register port
  input  wire logic [7:0]                      reg_addr_in,
  input  wire logic [7:0]                      reg_wdata_in,
  input  wire logic                            reg_wr_in,
  input  wire logic                            reg_rd_in,
  output logic      [7:0]                      reg_rdata_out,
  // pins
  input  wire logic                            on_off_in,
  input  wire logic                            ext_dim_in,
  input  wire logic [ldm_pkg::LDM_STRINGS-1:0] open_det_in,
  input  wire logic [ldm_pkg::LDM_STRINGS-1:0] short_det_in,
  output logic      [ldm_pkg::LDM_STRINGS-1:0] string_outputs_out,
  output logic                                 fault_n_out
);
  import ldm_pkg::*;

  localparam int unsigned NS = LDM_STRINGS;

  // product of duty and intensity, top eight bits
  function automatic logic [7:0] ldm_on_ticks(input logic [7:0] duty,
                                              input logic [5:0] intens);
    logic [13:0] prod;
    prod = 14'(duty) * 14'(intens);
    return prod[13:LDM_PROD_LSB];
  endfunction : ldm_on_ticks

  // frame position inside [phase, phase+on)
  function automatic logic ldm_in_window(input logic [7:0] pos,
                                         input logic [7:0] phase,
                                         input logic [7:0] on_t);
    logic [8:0] stop;
    stop = {1'b0, phase} + {1'b0, on_t};
    return ({1'b0, pos} >= {1'b0, phase}) && ({1'b0, pos} < stop);
  endfunction : ldm_in_window

  // pin synchronisers
  logic            en_meta_q;
  logic            en_s_q;
  logic            dim_meta_q;
  logic            dim_s_q;
  ldm_fault_t      det_meta_q;
  ldm_fault_t      det_s_q;

  // state
  logic [15:0]     div_q;
  logic [15:0]     div_d;
  logic [7:0]      frame_q;
  logic [7:0]      frame_d;
  logic [8:0]      high_q;
  logic [8:0]      high_d;
  logic [5:0]      meas_q;
  logic [5:0]      meas_d;
  ldm_mode_t       mode_q;
  ldm_mode_t       mode_d;
  logic [5:0]      intens_q;
  logic [5:0]      intens_d;
  ldm_str_cfg_t    cfg_q [NS];
  ldm_str_cfg_t    cfg_d [NS];
  ldm_fault_t      flags_q;
  ldm_fault_t      flags_d;
  logic [NS-1:0]   str_q;
  logic [NS-1:0]   str_d;
  logic            fault_n_q;
  logic            fault_n_d;
  logic [7:0]      rdata_q;
  logic [7:0]      rdata_d;

  // enable and dim sync stages start high, matching the pull-up on the pin, detector stages start low
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      en_meta_q  <= 1'b1;
      en_s_q     <= 1'b1;
      dim_meta_q <= 1'b1;
      dim_s_q    <= 1'b1;
      det_meta_q <= '0;
      det_s_q    <= '0;
    end
    else
    begin
      en_meta_q  <= on_off_in;
      en_s_q     <= en_meta_q;
      dim_meta_q <= ext_dim_in;
      dim_s_q    <= dim_meta_q;
      det_meta_q <= '{open_flags: open_det_in, short_flags: short_det_in};
      det_s_q    <= det_meta_q;
    end
  end

  always_comb
  begin
    logic       tick;
    logic       frame_end;
    logic [8:0] meas_full;
    logic [5:0] g_sel;
    logic [7:0] on_t;
    logic       win;
    logic       gate_ok;
    logic [3:0] idx;
    tick      = 1'b0;
    frame_end = 1'b0;
    meas_full = '0;
    g_sel     = '0;
    on_t      = '0;
    win       = 1'b0;
    gate_ok   = 1'b1;
    idx       = reg_addr_in[3:0];
    div_d     = div_q;
    frame_d   = frame_q;
    high_d    = high_q;
    meas_d    = meas_q;
    mode_d    = mode_q;
    intens_d  = intens_q;
    cfg_d     = cfg_q;
    flags_d   = flags_q;
    rdata_d   = '0;

    // duty tick divider
    if (div_q == 16'(TICK_DIV - 1))
    begin
      div_d = '0;
      tick  = 1'b1;
    end
    else
    begin
      div_d = div_q + 16'h0001;
    end
    if (tick)
    begin
      frame_d   = frame_q + 8'h01;
      frame_end = (frame_q == LDM_FRAME_LAST);
    end

    // count high ticks per frame, scale 256 ticks onto 0..63
    if (frame_end)
    begin
      meas_full = 9'(high_q + 9'(dim_s_q)) >> 2;
      meas_d    = (meas_full > 9'(LDM_INTENS_MAX)) ? LDM_INTENS_MAX : meas_full[5:0];
      high_d    = '0;
    end
    else if (tick)
    begin
      high_d = 9'(high_q + 9'(dim_s_q));
    end

    // register writes
    if (reg_wr_in)
    begin
      if (reg_addr_in == LDM_CTRL_ADDR)
      begin
        // code 3 is not a mode and is dropped
        if (reg_wdata_in[LDM_MODE_LSB +: 2] != 2'h3)
        begin
          mode_d = ldm_mode_t'(reg_wdata_in[LDM_MODE_LSB +: 2]);
        end
      end
      else if (reg_addr_in == LDM_INTENS_ADDR)
      begin
        intens_d = reg_wdata_in[5:0];
      end
      else if (reg_addr_in == LDM_OPEN_ADDR)
      begin
        flags_d.open_flags = flags_q.open_flags & ~reg_wdata_in;
      end
      else if (reg_addr_in == LDM_SHORT_ADDR)
      begin
        flags_d.short_flags = flags_q.short_flags & ~reg_wdata_in;
      end
      else if (reg_addr_in[7:4] == LDM_DUTY_BASE && idx < 4'(NS))
      begin
        cfg_d[idx[2:0]].duty = reg_wdata_in;
      end
      else if (reg_addr_in[7:4] == LDM_PHASE_BASE && idx < 4'(NS))
      begin
        cfg_d[idx[2:0]].phase = reg_wdata_in;
      end
    end

    // sticky fault flags, a new fault beats a clear
    flags_d.open_flags  = flags_d.open_flags | det_s_q.open_flags;
    flags_d.short_flags = flags_d.short_flags | det_s_q.short_flags;
    // high when no flag is set
    fault_n_d = ~(|flags_d.open_flags | |flags_d.short_flags);

    // internal mode reads only the programmed intensity
    // measured duty stands in for intensity otherwise
    g_sel = (mode_q == LDM_MODE_INTERNAL) ? intens_q : meas_q;
    // gated mode follows the input level
    gate_ok = (mode_q != LDM_MODE_GATED) || dim_s_q;
    for (int i = 0; i < NS; i++)
    begin
      // combined with the measured duty in external and gated modes
      // top eight bits of the product
      on_t = ldm_on_ticks(cfg_q[i].duty, g_sel);
      // start after phase delay ticks, no wrap past frame end
      win = ldm_in_window(frame_q, cfg_q[i].phase, on_t);
      str_d[i] = en_s_q && gate_ok && win;
    end

    // register reads, data the cycle after the strobe
    if (reg_rd_in)
    begin
      if (reg_addr_in == LDM_CTRL_ADDR)
      begin
        rdata_d = 8'(mode_q);
      end
      else if (reg_addr_in == LDM_INTENS_ADDR)
      begin
        rdata_d = {2'h0, intens_q};
      end
      else if (reg_addr_in == LDM_STAT_ADDR)
      begin
        rdata_d[LDM_STAT_EN]    = en_s_q;
        rdata_d[LDM_STAT_FAULT] = ~fault_n_q;
      end
      else if (reg_addr_in == LDM_OPEN_ADDR)
      begin
        rdata_d = flags_q.open_flags;
      end
      else if (reg_addr_in == LDM_SHORT_ADDR)
      begin
        rdata_d = flags_q.short_flags;
      end
      else if (reg_addr_in == LDM_MEAS_ADDR)
      begin
        rdata_d = {2'h0, meas_q};
      end
      else if (reg_addr_in[7:4] == LDM_DUTY_BASE && idx < 4'(NS))
      begin
        rdata_d = cfg_q[idx[2:0]].duty;
      end
      else if (reg_addr_in[7:4] == LDM_PHASE_BASE && idx < 4'(NS))
      begin
        rdata_d = cfg_q[idx[2:0]].phase;
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      div_q     <= '0;
      frame_q   <= '0;
      high_q    <= '0;
      meas_q    <= LDM_MEAS_RST;
      mode_q    <= LDM_MODE_INTERNAL;
      intens_q  <= LDM_INTENS_RST;
      flags_q   <= '0;
      str_q     <= '0;
      fault_n_q <= 1'b1;
      rdata_q   <= '0;
      for (int i = 0; i < NS; i++)
      begin
        cfg_q[i].duty  <= LDM_DUTY_RST;
        cfg_q[i].phase <= 8'(LDM_PHASE_STEP * 8'(i / 2));
      end
    end
    else
    begin
      div_q     <= div_d;
      frame_q   <= frame_d;
      high_q    <= high_d;
      meas_q    <= meas_d;
      mode_q    <= mode_d;
      intens_q  <= intens_d;
      flags_q   <= flags_d;
      str_q     <= str_d;
      fault_n_q <= fault_n_d;
      rdata_q   <= rdata_d;
      cfg_q     <= cfg_d;
    end
  end

  assign string_outputs_out = str_q;
  assign fault_n_out        = fault_n_q;
  assign reg_rdata_out      = rdata_q;
endmodule : ldm_dimming_ctrl
`default_nettype wire

// ---- rtl/ldm_pkg.sv ----
// package: register map, reset values and types of the dimming block
package ldm_pkg;
  localparam int unsigned LDM_STRINGS  = 8;
  localparam int unsigned LDM_TICK_DIV = 8;
  // register offsets
  localparam logic [7:0] LDM_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] LDM_INTENS_ADDR = 8'h01;
  localparam logic [7:0] LDM_STAT_ADDR   = 8'h02;
  localparam logic [7:0] LDM_OPEN_ADDR   = 8'h03;
  localparam logic [7:0] LDM_SHORT_ADDR  = 8'h04;
  localparam logic [7:0] LDM_MEAS_ADDR   = 8'h05;
  localparam logic [3:0] LDM_DUTY_BASE   = 4'h1;
  localparam logic [3:0] LDM_PHASE_BASE  = 4'h2;
  // field positions and limits
  localparam int unsigned LDM_MODE_LSB   = 0;
  localparam int unsigned LDM_STAT_EN    = 0;
  localparam int unsigned LDM_STAT_FAULT = 1;
  localparam int unsigned LDM_PROD_LSB   = 6;
  localparam logic [5:0] LDM_INTENS_MAX  = 6'h3f;
  localparam logic [7:0] LDM_FRAME_LAST  = 8'hff;
  // reset values
  localparam logic [5:0] LDM_INTENS_RST  = 6'h3f;
  localparam logic [7:0] LDM_DUTY_RST    = 8'h30;
  localparam logic [7:0] LDM_PHASE_STEP  = 8'h20;
  localparam logic [5:0] LDM_MEAS_RST    = 6'h3f;

  typedef enum logic [1:0] {
    LDM_MODE_INTERNAL,
    LDM_MODE_EXTERNAL,
    LDM_MODE_GATED
  } ldm_mode_t;

  typedef struct packed {
    logic [7:0] duty;
    logic [7:0] phase;
  } ldm_str_cfg_t;

  typedef struct packed {
    logic [7:0] open_flags;
    logic [7:0] short_flags;
  } ldm_fault_t;
endpackage : ldm_pkg

// ---- sim/ldm_dimming_ctrl_bench.sv ----
// bench: scenarios for the dimming block
`timescale 1ns/10ps
`default_nettype none
module ldm_dimming_ctrl_bench;
  import ldm_pkg::*;
  logic       clk, rst, wr, rd, on_off, dim, fault_n, run;
  logic [7:0] addr, wdata, rdata, open_det, short_det, outs, high;
  logic [8:0] cnt [9];
  int         n_mismatch;
  int         n_tests;
  ldm_dimming_ctrl #(.TICK_DIV(1)) uut (.ref_clk_in(clk), .sys_rst_in(rst),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .on_off_in(on_off), .ext_dim_in(dim),
    .open_det_in(open_det), .short_det_in(short_det),
    .string_outputs_out(outs), .fault_n_out(fault_n));
  ldm_host_model u_host (.ref_clk_in(clk), .sys_rst_in(rst), .run_in(run),
    .high_in(high), .ext_dim_out(dim));
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk8
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    #1 chk8(rdata, e);
  endtask : rd_chk
  // settle two frames, then count on cycles over the next
  task automatic frame_cnt();
    repeat (512) @(posedge clk);
    foreach (cnt[i]) cnt[i] = 9'h000;
    repeat (256)
    begin
      @(posedge clk);
      #1 foreach (cnt[i]) cnt[i] += {8'h00, (i < 8) ? outs[i[2:0]] : (outs[0] & ~outs[1])};
    end
  endtask : frame_cnt
  task automatic t_reset();
    logic [7:0] a [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h10, 8'h27, 8'h80};
    logic [7:0] e [8] = '{8'h00, 8'h3f, 8'h01, 8'h00, 8'h3f, 8'h30, 8'h60, 8'h00};
    foreach (a[i]) rd_chk(a[i], e[i]);
    $display("test reset done");
  endtask : t_reset
  task automatic t_fault();
    chk8({7'h00, fault_n}, 8'h01);
    @(posedge clk) open_det <= 8'h04;
    repeat (6) @(posedge clk);
    open_det <= 8'h00;
    short_det <= 8'h20;
    repeat (6) @(posedge clk);
    short_det <= 8'h00;
    #1 chk8({7'h00, fault_n}, 8'h00);
    rd_chk(LDM_STAT_ADDR, 8'h03);
    rd_chk(LDM_OPEN_ADDR, 8'h04);
    rd_chk(LDM_SHORT_ADDR, 8'h20);
    wr_reg(LDM_OPEN_ADDR, 8'hff);
    wr_reg(LDM_SHORT_ADDR, 8'hff);
    repeat (3) @(posedge clk);
    #1 chk8({7'h00, fault_n}, 8'h01);
    rd_chk(LDM_OPEN_ADDR, 8'h00);
    $display("test fault done");
  endtask : t_fault
  task automatic t_window();
    wr_reg(8'h10, 8'h80);
    wr_reg(8'h11, 8'h80);
    wr_reg(8'h12, 8'h80);
    wr_reg(8'h13, 8'h00);
    wr_reg(8'h20, 8'h00);
    wr_reg(8'h21, 8'h40);
    wr_reg(8'h22, 8'h40);
    frame_cnt();
    chk8(cnt[0][7:0], 8'h7e);
    chk8(cnt[2][7:0], 8'h7e);
    chk8(cnt[3][7:0], 8'h00);
    chk8(cnt[4][7:0], 8'h2f);
    chk8(cnt[6][7:0], 8'h2f);
    chk8(cnt[8][7:0], 8'h40);
    wr_reg(LDM_INTENS_ADDR, 8'h20);
    frame_cnt();
    chk8(cnt[0][7:0], 8'h40);
    chk8(cnt[4][7:0], 8'h18);
    chk8(cnt[5][7:0], 8'h18);
    wr_reg(LDM_INTENS_ADDR, 8'h3f);
    $display("test window done");
  endtask : t_window
  task automatic t_off();
    @(posedge clk) on_off <= 1'b0;
    frame_cnt();
    chk8(cnt[4][7:0], 8'h00);
    rd_chk(LDM_STAT_ADDR, 8'h00);
    @(posedge clk) on_off <= 1'b1;
    $display("test off done");
  endtask : t_off
  task automatic t_ext();
    wr_reg(LDM_CTRL_ADDR, 8'h01);
    wr_reg(LDM_CTRL_ADDR, 8'h03);
    rd_chk(LDM_CTRL_ADDR, 8'h01);
    frame_cnt();
    rd_chk(LDM_MEAS_ADDR, 8'h20);
    chk8(cnt[0][7:0], 8'h40);
    chk8(cnt[4][7:0], 8'h18);
    chk8(cnt[7][7:0], 8'h18);
    $display("test external done");
  endtask : t_ext
  task automatic t_gated();
    wr_reg(LDM_CTRL_ADDR, 8'h02);
    wr_reg(8'h10, 8'hff);
    @(posedge clk) run <= 1'b0;
    frame_cnt();
    chk8(cnt[0][7:0], 8'hfb);
    rd_chk(LDM_MEAS_ADDR, 8'h3f);
    @(posedge clk) {run, high} <= {1'b1, 8'h00};
    frame_cnt();
    chk8(cnt[0][7:0], 8'h00);
    $display("test gated done");
  endtask : t_gated
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    {rst, addr, wdata, wr, rd} = {1'b1, 18'h0};
    {on_off, open_det, short_det, run, high} = {1'b1, 16'h0, 1'b1, 8'h80};
    n_mismatch = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fault();
    t_window();
    t_off();
    t_ext();
    t_gated();
    stop_test();
  end
  initial
  begin
    #2000000;
    n_mismatch++;
    stop_test();
  end
endmodule : ldm_dimming_ctrl_bench
`default_nettype wire

// ---- sim/ldm_dimming_props.sv ----
// checker: port assertions of the dimming block
`timescale 1ns/10ps
`default_nettype none
module ldm_dimming_props
  import ldm_pkg::*;
(
  // clock and reset
  input wire logic       ref_clk_in,
  input wire logic       sys_rst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // pins
  input wire logic       on_off_in,
  input wire logic       ext_dim_in,
  input wire logic [7:0] open_det_in,
  input wire logic [7:0] short_det_in,
  input wire logic [7:0] string_outputs_out,
  input wire logic       fault_n_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic       det;
  assign det = |{open_det_in, short_det_in};
  // shadow of the mode, code 3 refused
  always_comb
  begin
    mode_d = mode_q;
    if (reg_wr_in && reg_addr_in == LDM_CTRL_ADDR && reg_wdata_in[1:0] != 2'h3)
      mode_d = reg_wdata_in[1:0];
    if (sys_rst_in)
      mode_d = 2'h0;
  end
  always_ff @(posedge ref_clk_in)
  begin
    mode_q <= mode_d;
  end
  sequence rd_void;
    reg_rd_in && reg_addr_in == 8'h80;
  endsequence
  sequence pin_off;
    !on_off_in [*4];
  endsequence
  sequence gate_low;
    (mode_q == 2'h2 && !ext_dim_in) [*4];
  endsequence
  on_needed_a: assert property (|string_outputs_out |-> $past(on_off_in, 3))
    else $error("string on without enable");
  off_clears_a: assert property (pin_off |=> string_outputs_out == 8'h00)
    else $error("string on while disabled");
  gated_off_a: assert property (gate_low |=> string_outputs_out == 8'h00)
    else $error("gated string on while input low");
  rd_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside read cycle");
  rd_void_a: assert property (rd_void |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  fault_set_a: assert property (det [*4] |=> !fault_n_out)
    else $error("fault not signalled");
  fault_src_a: assert property ($fell(fault_n_out) |-> $past(det, 3) || $past(det, 4))
    else $error("fault signalled without cause");
  fault_hold_a: assert property (!fault_n_out && $past(det, 2) |=> !fault_n_out)
    else $error("fault released while detector high");
endmodule : ldm_dimming_props
bind ldm_dimming_ctrl ldm_dimming_props u_props (.ref_clk_in, .sys_rst_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .on_off_in, .ext_dim_in,
  .open_det_in, .short_det_in, .string_outputs_out, .fault_n_out);
`default_nettype wire

// ---- sim/ldm_host_model.sv ----
// far side model: dimming waveform source, period of 256 clocks
`timescale 1ns/10ps
`default_nettype none
module ldm_host_model
(
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  // waveform shape
  input  wire logic       run_in,
  input  wire logic [7:0] high_in,
  // pin
  output logic            ext_dim_out
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       dim_d;
  always_comb
  begin
    cnt_d = sys_rst_in ? 8'h00 : cnt_q + 8'h01;
    dim_d = !run_in || (cnt_q < high_in);
  end
  always_ff @(posedge ref_clk_in)
  begin
    cnt_q <= cnt_d;
    ext_dim_out <= dim_d;
  end
endmodule : ldm_host_model
`default_nettype wire
